// ==== hw/lpwc_top.sv ====
// lpwc_top: low-power mode selection, wake-up detection and restart sequencing.
// assumes wait instructions arrive as one-cycle pulses and all inputs are synchronous to MCLK.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module lpwc_top
   import lpwc_pkg::*;
#(
   parameter int REG_START_CYCLES = REG_START_CYC,
   parameter int RC_START_CYCLES = RC_START_CYC,
   parameter int CORE_RST_CYCLES = CORE_RST_CYC
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // register port
   input wire logic [lpwc_pkg::ADDR_W-1:0] ADDR,
   input wire logic [lpwc_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [lpwc_pkg::DATA_W-1:0] RDATA,
   // processor core
   input wire logic WAIT_FOR_IRQ_INSN,
   input wire logic WAIT_FOR_EVENT_INSN,
   input wire logic CORE_IRQ,
   input wire logic CORE_EVENT,
   // wake sources, low active except the supply monitor alarm
   input wire logic [lpwc_pkg::N_PINS-1:0] WAKE_INPUT_PINS_N,
   input wire logic RTC_ALARM_N,
   input wire logic REAL_TIME_TICKER_ALARM_N,
   input wire logic USB_WAKE_N,
   input wire logic FORCE_WAKE_PIN_N,
   input wire logic SM_ALARM,
   // power manager and supply controller
   output logic FAST_STARTUP,
   output logic CORE_CLK_EN,
   output logic PERIPH_CLK_EN,
   output logic FAST_RC_EN,
   output logic MASTER_CLK_SRC,
   output logic [1:0] FAST_RC_FREQ,
   output logic REGULATOR_ON_CTRL,
   output logic CORE_RESET,
   // interrupt
   output logic IRQ
);
   import lpwc_pkg::*;

   if (REG_START_CYCLES < 1 || REG_START_CYCLES >= (1 << CNT_W)) begin : g_chk_reg
      $error("REG_START_CYCLES out of range");
   end
   if (RC_START_CYCLES < 1 || RC_START_CYCLES > 1000) begin : g_chk_rc
      $error("RC_START_CYCLES out of range");
   end
   if (CORE_RST_CYCLES < 1 || CORE_RST_CYCLES > 1000) begin : g_chk_rst
      $error("CORE_RST_CYCLES out of range");
   end

   lpwc_state_t state_q, state_d;
   logic [1:0] mode_q;
   logic [N_WAKE-1:0] wake_en_q;
   logic [0:0] domain_q;
   logic [0:0] clk_src_q;
   logic [1:0] rc_freq_q;
   logic [2:0] irq_stat_q, irq_mask_q, irq_set;
   logic [CNT_W-1:0] cnt_q;
   logic [N_WAKE-1:0] wake_lvl;
   logic fast_any, backup_any, cnt_done, rd_stat;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n - 1);
   endfunction : cyc

   // active-high view of every wake source
   assign wake_lvl = {SM_ALARM, ~FORCE_WAKE_PIN_N, ~USB_WAKE_N, ~REAL_TIME_TICKER_ALARM_N,
      ~RTC_ALARM_N, ~WAKE_INPUT_PINS_N};
   // only the 19 fast inputs count here; backup wake uses pins, force, alarms and supply
   assign fast_any = |(wake_lvl[N_FAST-1:0] & wake_en_q[N_FAST-1:0]);
   assign backup_any = |(wake_lvl & wake_en_q & ~(N_WAKE'(1) << WAKE_USB_BIT));
   assign cnt_done = (cnt_q == '0);

   // pure gates from the pins: the request must rise while no clock runs in wait
   assign FAST_STARTUP = (state_q == ST_WAIT) && fast_any;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_ACTIVE: begin
            if (WAIT_FOR_IRQ_INSN && !mode_q[MODE_LPS_BIT]) begin
               state_d = ST_SLEEP_IRQ;
            end else if (WAIT_FOR_EVENT_INSN) begin
               if (mode_q[MODE_DEEP_BIT]) begin
                  state_d = ST_BACKUP;
               end else if (mode_q[MODE_LPS_BIT]) begin
                  state_d = ST_WAIT;
               end else begin
                  state_d = ST_SLEEP_EVT;
               end
            end
         end
         ST_SLEEP_IRQ: begin
            if (CORE_IRQ) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_SLEEP_EVT: begin
            if (CORE_IRQ || CORE_EVENT || fast_any) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_WAIT: begin
            if (FAST_STARTUP) begin
               state_d = ST_RC_START;
            end
         end
         ST_RC_START: begin
            if (cnt_done) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_BACKUP: begin
            if (backup_any) begin
               state_d = ST_REG_START;
            end
         end
         ST_REG_START: begin
            if (cnt_done) begin
               state_d = ST_CORE_RST;
            end
         end
         ST_CORE_RST: begin
            if (cnt_done) begin
               state_d = ST_ACTIVE;
            end
         end
         default: state_d = ST_ACTIVE;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         state_q <= ST_ACTIVE;
      end else begin
         state_q <= state_d;
      end
   end

   // one counter serves the three timed phases; loaded on entry
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cnt_q <= '0;
      end else if (state_q != state_d) begin
         case (state_d)
            ST_RC_START: cnt_q <= cyc(RC_START_CYCLES);
            ST_REG_START: cnt_q <= cyc(REG_START_CYCLES);
            ST_CORE_RST: cnt_q <= cyc(CORE_RST_CYCLES);
            default: cnt_q <= '0;
         endcase
      end else if (!cnt_done) begin
         cnt_q <= cnt_q - CNT_W'(1);
      end
   end

   // clock and supply outputs registered from the next state
   always_ff @(posedge MCLK) begin
      if (RST) begin
         CORE_CLK_EN <= 1'b1;
         PERIPH_CLK_EN <= 1'b1;
         FAST_RC_EN <= 1'b1;
         REGULATOR_ON_CTRL <= 1'b1;
         CORE_RESET <= 1'b0;
      end else begin
         CORE_CLK_EN <= (state_d == ST_ACTIVE);
         PERIPH_CLK_EN <= (state_d == ST_ACTIVE) || (domain_q[DOM_PERIPH_BIT] &&
            (state_d == ST_SLEEP_IRQ || state_d == ST_SLEEP_EVT));
         FAST_RC_EN <= !(state_d == ST_WAIT || state_d == ST_BACKUP);
         REGULATOR_ON_CTRL <= (state_d != ST_BACKUP);
         CORE_RESET <= (state_d == ST_CORE_RST);
      end
   end

   // master clock falls back to the fast RC at 4 MHz on every restart; no PLL here
   always_ff @(posedge MCLK) begin
      if (RST) begin
         clk_src_q <= SRC_FAST_RC;
         rc_freq_q <= RC_FREQ_4MHZ;
      end else if (state_d == ST_RC_START || state_d == ST_CORE_RST) begin
         clk_src_q <= SRC_FAST_RC;
         rc_freq_q <= RC_FREQ_4MHZ;
      end else if (WR && ADDR == OFS_CLK) begin
         clk_src_q <= WDATA[CLK_SRC_BIT];
         rc_freq_q <= WDATA[CLK_FREQ_LSB +: 2];
      end
   end
   assign MASTER_CLK_SRC = clk_src_q;
   assign FAST_RC_FREQ = rc_freq_q;

   // control registers
   always_ff @(posedge MCLK) begin
      if (RST) begin
         mode_q <= MODE_RST;
         wake_en_q <= WAKE_EN_RST;
         domain_q <= DOMAIN_RST;
         irq_mask_q <= IRQ_RST;
      end else if (WR) begin
         case (ADDR)
            OFS_MODE: mode_q <= WDATA[1:0];
            OFS_WAKE_EN: wake_en_q <= WDATA[N_WAKE-1:0];
            OFS_DOMAIN: domain_q <= WDATA[0:0];
            OFS_IRQ_MASK: irq_mask_q <= WDATA[2:0];
            default: ;
         endcase
      end
   end

   // wake events: sticky, cleared by reading, a new event wins over the clear
   assign irq_set = {state_q == ST_CORE_RST && state_d == ST_ACTIVE,
      state_q == ST_RC_START && state_d == ST_ACTIVE,
      (state_q == ST_SLEEP_IRQ || state_q == ST_SLEEP_EVT) && state_d == ST_ACTIVE};
   assign rd_stat = RD && (ADDR == OFS_IRQ_STAT);
   always_ff @(posedge MCLK) begin
      if (RST) begin
         irq_stat_q <= IRQ_RST;
      end else begin
         irq_stat_q <= (rd_stat ? 3'h0 : irq_stat_q) | irq_set;
      end
   end
   assign IRQ = |(irq_stat_q & irq_mask_q);

   // read data valid only in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge MCLK) begin
      if (RST) begin
         RDATA <= '0;
      end else if (RD) begin
         case (ADDR)
            OFS_MODE: RDATA <= DATA_W'(mode_q);
            OFS_WAKE_EN: RDATA <= DATA_W'(wake_en_q);
            OFS_DOMAIN: RDATA <= DATA_W'(domain_q);
            OFS_CLK: RDATA <= DATA_W'({rc_freq_q, clk_src_q});
            OFS_STATUS: RDATA <= DATA_W'({REGULATOR_ON_CTRL, FAST_RC_EN, PERIPH_CLK_EN,
               CORE_CLK_EN, 1'b0, state_q});
            OFS_IRQ_STAT: RDATA <= DATA_W'(irq_stat_q);
            OFS_IRQ_MASK: RDATA <= DATA_W'(irq_mask_q);
            default: RDATA <= '0;
         endcase
      end else begin
         RDATA <= '0;
      end
   end

   AST_SLEEP_PERIPH: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_ACTIVE && WAIT_FOR_IRQ_INSN && !mode_q[MODE_LPS_BIT])
      |=> (!CORE_CLK_EN && PERIPH_CLK_EN == domain_q[DOM_PERIPH_BIT]))
      else $error("sleep entry clock gating wrong");
   AST_SLEEP_ENTRY: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_ACTIVE && WAIT_FOR_EVENT_INSN && mode_q == 2'h0 && !WAIT_FOR_IRQ_INSN)
      |=> (state_q == ST_SLEEP_EVT && REGULATOR_ON_CTRL))
      else $error("event-wait with select 0 did not sleep");
   AST_EVT_RESUME: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_SLEEP_EVT && CORE_EVENT) |=> (CORE_CLK_EN && !CORE_RESET))
      else $error("event did not resume core");
   AST_IRQ_ONLY: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_SLEEP_IRQ && !CORE_IRQ) |=> !CORE_CLK_EN)
      else $error("irq-wait sleep woke without interrupt");
   AST_WAKE_ENABLE: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_BACKUP && !(|(wake_lvl & wake_en_q))) |=> state_q == ST_BACKUP)
      else $error("backup left without enabled source");
   AST_BACKUP_SUPPLY: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_BACKUP && backup_any) |=> (REGULATOR_ON_CTRL ##1 REGULATOR_ON_CTRL))
      else $error("backup wake did not restore supply");
   AST_FAST_PIN: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_WAIT && !WAKE_INPUT_PINS_N[0] && wake_en_q[0]) |-> FAST_STARTUP)
      else $error("enabled low wake pin gave no fast startup");
   AST_FAST_ONLY_WAIT: assert property (@(posedge MCLK) disable iff (RST)
      FAST_STARTUP |-> (!CORE_CLK_EN && !FAST_RC_EN))
      else $error("fast startup outside wait");
   AST_FAST_RESTART: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_WAIT && FAST_STARTUP) |=> FAST_RC_EN ##[1:1000]
      (CORE_CLK_EN && FAST_RC_FREQ == 2'h0))
      else $error("fast startup did not restore clock");
   AST_RC_AFTER_WAKE: assert property (@(posedge MCLK) disable iff (RST)
      ($rose(CORE_CLK_EN) && $past(state_q) != ST_SLEEP_IRQ && $past(state_q) != ST_SLEEP_EVT)
      |-> MASTER_CLK_SRC == 1'b0)
      else $error("wake not on fast RC");
   AST_WAIT_ENTRY: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_ACTIVE && WAIT_FOR_EVENT_INSN && mode_q == 2'h1 && !WAIT_FOR_IRQ_INSN)
      |=> (!PERIPH_CLK_EN && !CORE_CLK_EN && REGULATOR_ON_CTRL))
      else $error("wait entry wrong");
   AST_BACKUP_RESET: assert property (@(posedge MCLK) disable iff (RST)
      $fell(CORE_RESET) |-> (CORE_CLK_EN && $past(REGULATOR_ON_CTRL, 2)))
      else $error("backup restart not through reset");
   AST_REG_OFF: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_ACTIVE && WAIT_FOR_EVENT_INSN && mode_q[MODE_DEEP_BIT] &&
      !(WAIT_FOR_IRQ_INSN && !mode_q[MODE_LPS_BIT])) |=> !REGULATOR_ON_CTRL)
      else $error("regulator left on in backup");
endmodule : lpwc_top

// ==== inc/lpwc_pkg.sv ====
// lpwc_pkg: constants, register map and state type of the low-power mode / wake-up controller.
// assumes a 50 MHz master clock and a plain strobe-based register port.
package lpwc_pkg;
   // register port
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam logic [4:0] OFS_MODE = 5'h00;
   localparam logic [4:0] OFS_WAKE_EN = 5'h04;
   localparam logic [4:0] OFS_DOMAIN = 5'h08;
   localparam logic [4:0] OFS_CLK = 5'h0C;
   localparam logic [4:0] OFS_STATUS = 5'h10;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
   // wake source layout: pins 0..15, then rtc, rtt, usb, force pin, supply monitor
   localparam int N_PINS = 16;
   localparam int N_FAST = 19;
   localparam int N_WAKE = 21;
   localparam int WAKE_RTC_BIT = 16;
   localparam int WAKE_RTT_BIT = 17;
   localparam int WAKE_USB_BIT = 18;
   localparam int WAKE_FORCE_BIT = 19;
   localparam int WAKE_SM_BIT = 20;
   // field positions
   localparam int MODE_LPS_BIT = 0;
   localparam int MODE_DEEP_BIT = 1;
   localparam int DOM_PERIPH_BIT = 0;
   localparam int CLK_SRC_BIT = 0;
   localparam int CLK_FREQ_LSB = 1;
   localparam int IRQ_SLEEP_BIT = 0;
   localparam int IRQ_WAIT_BIT = 1;
   localparam int IRQ_BACKUP_BIT = 2;
   localparam int STAT_CORE_BIT = 4;
   localparam int STAT_PERIPH_BIT = 5;
   localparam int STAT_RC_BIT = 6;
   localparam int STAT_REG_BIT = 7;
   // reset values
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [20:0] WAKE_EN_RST = 21'h0;
   localparam logic [0:0] DOMAIN_RST = 1'h1;
   localparam logic [1:0] RC_FREQ_4MHZ = 2'h0;
   localparam logic [0:0] SRC_FAST_RC = 1'h0;
   localparam logic [2:0] IRQ_RST = 3'h0;
   // timing
   localparam int MCLK_KHZ = 50000;
   localparam int RC_START_NS = 5000;
   localparam int RC_START_CYC = (RC_START_NS * MCLK_KHZ + 999999) / 1000000;
   localparam int REG_START_US = 400;
   localparam int REG_START_CYC = (REG_START_US * MCLK_KHZ) / 1000;
   localparam int CORE_RST_NS = 100;
   localparam int CORE_RST_CYC = (CORE_RST_NS * MCLK_KHZ + 999999) / 1000000;
   localparam int CNT_W = 15;

   typedef enum logic [2:0] {
      ST_ACTIVE, ST_SLEEP_IRQ, ST_SLEEP_EVT, ST_WAIT, ST_RC_START, ST_BACKUP,
      ST_REG_START, ST_CORE_RST
   } lpwc_state_t;
endpackage : lpwc_pkg

// ==== verification/lpwc_core_model.sv ====
// lpwc_core_model: behavioural processor core that issues wait instructions and irq/event levels.
// assumes the bench requests each instruction for one cycle; outputs follow one edge later.
`timescale 1ns/10ps
module lpwc_core_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // bench commands
   input wire logic req_irqw,
   input wire logic req_evtw,
   input wire logic irq_lvl,
   input wire logic evt_lvl,
   input wire logic clk_en,
   // core side
   output logic wait_irq,
   output logic wait_evt,
   output logic core_irq,
   output logic core_evt
);
   // a gated core executes nothing, so requests are dropped while its clock is off
   always_ff @(posedge mclk) begin
      wait_irq <= !rst && req_irqw && clk_en;
      wait_evt <= !rst && req_evtw && clk_en;
      core_irq <= !rst && irq_lvl;
      core_evt <= !rst && evt_lvl;
   end
endmodule : lpwc_core_model

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench for the low-power mode and wake-up controller.
// assumes shortened start-up counts; wake inputs are kept in one vector, bit 20 inverted.
`timescale 1ns/10ps
module tb_top;
   import lpwc_pkg::*;
   localparam int RCC = 4;
   localparam int REGC = 20;
   logic mclk, rst, wr, rd, rq_i, rq_e, irq_l, evt_l;
   logic [4:0] addr;
   logic [31:0] wdata, rdata;
   logic [20:0] wk_n;
   logic wait_for_irq_insn, wait_for_event_insn, c_irq, c_evt, fst, cclk, pclk, rc_en, src, reg_on, crst, irq;
   logic [1:0] freq;
   int err_total, n_checks, cyc, n;
   int bsrc[5] = '{0, 16, 17, 19, 20};

   lpwc_core_model lpwc_core_model_i (.mclk(mclk), .rst(rst), .req_irqw(rq_i), .req_evtw(rq_e),
      .irq_lvl(irq_l), .evt_lvl(evt_l), .clk_en(cclk), .wait_irq(wait_for_irq_insn), .wait_evt(wait_for_event_insn),
      .core_irq(c_irq), .core_evt(c_evt));
   lpwc_top #(.REG_START_CYCLES(REGC), .RC_START_CYCLES(RCC), .CORE_RST_CYCLES(2)) lpwc_top_i (
      .MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .WAIT_FOR_IRQ_INSN(wait_for_irq_insn), .WAIT_FOR_EVENT_INSN(wait_for_event_insn), .CORE_IRQ(c_irq), .CORE_EVENT(c_evt),
      .WAKE_INPUT_PINS_N(wk_n[15:0]), .RTC_ALARM_N(wk_n[16]), .REAL_TIME_TICKER_ALARM_N(wk_n[17]),
      .USB_WAKE_N(wk_n[18]), .FORCE_WAKE_PIN_N(wk_n[19]), .SM_ALARM(~wk_n[20]),
      .FAST_STARTUP(fst), .CORE_CLK_EN(cclk), .PERIPH_CLK_EN(pclk), .FAST_RC_EN(rc_en),
      .MASTER_CLK_SRC(src), .FAST_RC_FREQ(freq), .REGULATOR_ON_CTRL(reg_on),
      .CORE_RESET(crst), .IRQ(irq));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // a hang in any wait loop ends here
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 20000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e,
         input logic [31:0] m = 32'hFFFFFFFF);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(nm, rdata & m, e);
   endtask : rd_chk

   // request one wait instruction; state has moved when this returns
   task automatic insn(input logic ev);
      @(posedge mclk);
      rq_e <= ev;
      rq_i <= !ev;
      @(posedge mclk);
      rq_e <= 1'b0;
      rq_i <= 1'b0;
      @(posedge mclk);
      #1;
   endtask : insn

   // polls core clock enable, or core reset when asked; gives up after 100 cycles
   task automatic wt(input bit on_rst, output int k);
      k = 0;
      while ((on_rst ? crst : cclk) !== 1'b1 && k < 100) begin
         @(posedge mclk);
         #1 k++;
      end
   endtask : wt

   task automatic idle(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : idle

   task automatic t_reset;
      chk("outs", {cclk, pclk, rc_en, reg_on, crst, src, freq, irq, fst}, 32'h3C0);
      rd_chk("mode", OFS_MODE, 32'h0);
      rd_chk("domain", OFS_DOMAIN, 32'h1);
      rd_chk("clk", OFS_CLK, 32'h0);
      rd_chk("status", OFS_STATUS, 32'hF0);
      rd_chk("unmapped", 5'h1C, 32'h0);
      wr_reg(OFS_WAKE_EN, 32'hFFFFFFFF);
      rd_chk("wake en", OFS_WAKE_EN, 32'h001FFFFF);
   endtask : t_reset

   task automatic t_sleep_irq;
      wr_reg(OFS_IRQ_MASK, 32'h7);
      wr_reg(OFS_MODE, 32'h1);
      insn(1'b0);
      chk("irqw lps1", cclk, 1'b1);
      wr_reg(OFS_MODE, 32'h0);
      insn(1'b0);
      chk("sleep clks", {cclk, pclk, reg_on}, 32'h3);
      rd_chk("state", OFS_STATUS, 32'h1, 32'h7);
      evt_l <= 1'b1;
      wk_n[0] <= 1'b0;
      idle(6);
      chk("irqw no event wake", cclk, 1'b0);
      @(posedge mclk);
      irq_l <= 1'b1;
      wt(1'b0, n);
      chk("irq wake", {cclk, irq, reg_on}, 32'h7);
      irq_l <= 1'b0;
      evt_l <= 1'b0;
      wk_n <= '1;
      rd_chk("irq stat", OFS_IRQ_STAT, 32'h1);
      chk("irq cleared", irq, 1'b0);
   endtask : t_sleep_irq

   task automatic t_sleep_evt;
      wr_reg(OFS_DOMAIN, 32'h0);
      wr_reg(OFS_IRQ_MASK, 32'h0);
      wr_reg(OFS_WAKE_EN, 32'h20);
      insn(1'b1);
      chk("evt sleep clks", {cclk, pclk}, 32'h0);
      rd_chk("state", OFS_STATUS, 32'h2, 32'h7);
      wk_n[4] <= 1'b0;
      idle(6);
      chk("disabled pin", cclk, 1'b0);
      @(posedge mclk);
      wk_n[5] <= 1'b0;
      wt(1'b0, n);
      chk("pin wake", {cclk, irq}, 32'h2);
      wk_n <= '1;
      rd_chk("irq stat", OFS_IRQ_STAT, 32'h1);
      insn(1'b1);
      evt_l <= 1'b1;
      wt(1'b0, n);
      chk("event wake", cclk, 1'b1);
      evt_l <= 1'b0;
      rd_chk("irq stat evt", OFS_IRQ_STAT, 32'h1);
      wr_reg(OFS_DOMAIN, 32'h1);
      wr_reg(OFS_IRQ_MASK, 32'h7);
   endtask : t_sleep_evt

   task automatic t_wait(input int i);
      wr_reg(OFS_WAKE_EN, 32'h1 << i);
      wr_reg(OFS_CLK, 32'h5);
      evt_l <= 1'b1;
      insn(1'b1);
      chk("wait clks", {cclk, pclk, rc_en, reg_on}, 32'h1);
      wk_n[(i + 1) % 19] <= 1'b0;
      idle(3);
      chk("no fast start", {fst, cclk}, 32'h0);
      wk_n[i] <= 1'b0;
      #1 chk("fast start", fst, 1'b1);
      wt(1'b0, n);
      chk("rc start time", n >= RCC && n <= RCC + 2, 1'b1);
      chk("clock source", {src, freq, rc_en}, 32'h1);
      evt_l <= 1'b0;
      wk_n <= '1;
      rd_chk("clk reg", OFS_CLK, 32'h0);
      rd_chk("irq stat", OFS_IRQ_STAT, 32'h2);
   endtask : t_wait

   task automatic t_backup(input int b);
      wr_reg(OFS_WAKE_EN, (32'h1 << b) | 32'h40000);
      wr_reg(OFS_MODE, 32'h2);
      wr_reg(OFS_CLK, 32'h5);
      insn(1'b1);
      chk("backup outs", {reg_on, cclk, pclk, rc_en}, 32'h0);
      rd_chk("state", OFS_STATUS, 32'h5, 32'h7);
      wk_n[18] <= 1'b0;
      idle(6);
      chk("usb in backup", reg_on, 1'b0);
      @(posedge mclk);
      wk_n[b] <= 1'b0;
      idle(1);
      chk("regulator back", reg_on, 1'b1);
      wt(1'b1, n);
      chk("reg start time", n >= REGC - 2 && n <= REGC + 2, 1'b1);
      wt(1'b0, n);
      chk("core restart", {cclk, crst, src, freq}, 32'h10);
      wk_n <= '1;
      rd_chk("irq stat", OFS_IRQ_STAT, 32'h4);
      wr_reg(OFS_MODE, 32'h0);
   endtask : t_backup

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 5'h00;
      wdata = 32'h0;
      rq_i = 1'b0;
      rq_e = 1'b0;
      irq_l = 1'b0;
      evt_l = 1'b0;
      wk_n = '1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1 t_reset();
      t_sleep_irq();
      t_sleep_evt();
      wr_reg(OFS_MODE, 32'h1);
      for (int i = 0; i < 19; i++) begin
         t_wait(i);
      end
      foreach (bsrc[j]) begin
         t_backup(bsrc[j]);
      end
      finish_test();
   end
endmodule : tb_top
